// [common/fractional_divider_lock_pkg.sv]
// Package: register map, field layout and lookup constants for the block
// What this block does
// - Seed choice stored, loaded on enabled frequency change
// - Seed codes map to four starting values
// - Bypass ignores modulator output; clocking follows core enable
// - Core enable picks which divider write calibrates
// - Core enable zero disables fractional core
// - Lock after programmed consecutive in-window comparisons
// - Count limit code maps to required count
// - Lock detector runs only while enabled
// - Zeroed VCO address arms divider-write calibration
// - Window length code maps to cycle count
package fractional_divider_lock_pkg;
   localparam int          ADDR_W = 5;
   localparam int          DATA_W = 24;
   // Register indices
   localparam logic [4:0]  IDX_INT_DIV  = 5'h03;
   localparam logic [4:0]  IDX_FRACTIONAL_DIVIDER_DIV = 5'h04;
   localparam logic [4:0]  IDX_VCO_SPI  = 5'h05;
   localparam logic [4:0]  IDX_MOD_CFG  = 5'h06;
   localparam logic [4:0]  IDX_LKD_CTL  = 5'h07;
   // Reset values
   localparam logic [23:0] MOD_CFG_RST  = 24'h20_0b4a;
   localparam logic [23:0] LKD_CTL_RST  = 24'h00_014d;
   localparam logic [22:0] MOD_CFG_MASK = 23'h7f_ffff;
   // Field positions
   localparam int          SEED_LSB     = 0;
   localparam int          BYPASS_BIT   = 7;
   localparam int          SEED_LD_BIT  = 8;
   localparam int          CORE_ON_BIT  = 11;
   localparam int          LIMIT_LSB    = 0;
   localparam int          LKD_ON_BIT   = 3;
   localparam int          WIN_LSB      = 7;
   localparam logic [6:0]  VCO_LOW_MASK = 7'h7f;
   // Seed values
   localparam logic [23:0] SEED_ZERO    = 24'h00_0000;
   localparam logic [23:0] SEED_LSBV    = 24'h00_0001;
   localparam logic [23:0] SEED_A       = 24'hb2_9d08;
   localparam logic [23:0] SEED_B       = 24'h50_f1cd;
   // Lock count limits
   localparam logic [16:0] LIM_0 = 17'h0_0005;
   localparam logic [16:0] LIM_1 = 17'h0_0020;
   localparam logic [16:0] LIM_2 = 17'h0_0060;
   localparam logic [16:0] LIM_3 = 17'h0_0100;
   localparam logic [16:0] LIM_4 = 17'h0_0200;
   localparam logic [16:0] LIM_5 = 17'h0_0800;
   localparam logic [16:0] LIM_6 = 17'h0_2000;
   localparam logic [16:0] LIM_7 = 17'h0_ffff;

   // Register write strobe with address and data
   typedef struct packed {
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } reg_wr_t;

   // Modulator control outputs
   typedef struct packed {
      logic        core_on;
      logic        use_mod;
      logic        seed_load;
      logic [23:0] seed;
   } mod_ctl_t;
endpackage

// [core/fractional_divider_lock_cfg.sv]
// Module: modulator configuration and digital lock detector registers
`timescale 1ns/100ps
module fractional_divider_lock_cfg
(
   input  wire logic                   i_clk,      // 100 MHz clock
   input  wire logic                   i_arst_n,   // Async reset, low
   input  wire logic                   i_ce,       // Clock enable
   input  wire fractional_divider_lock_pkg::reg_wr_t i_wr,       // Register write
   input  wire logic [4:0]             i_rd_addr,  // Read index
   input  wire logic                   i_freq_chg, // Frequency change pulse
   input  wire logic                   i_cmp,      // Comparison done, async
   input  wire logic                   i_in_win,   // Comparison in window
   output logic [23:0]                 o_rd_data,  // Read data, registered
   output fractional_divider_lock_pkg::mod_ctl_t     o_mod,      // Modulator control
   output logic [6:0]                  o_win_len,  // Window length cycles
   output logic                        o_win_half, // Half-cycle window
   output logic                        o_cal_start,// Autocalibration pulse
   output logic                        o_locked    // Lock indication
);
   import fractional_divider_lock_pkg::*;

   // Reset images of the decoded outputs, taken from the register resets
   localparam logic [2:0] WIN_RST      = LKD_CTL_RST[WIN_LSB +: 3];
   localparam logic       WIN_HALF_RST = WIN_RST == 3'd0;
   localparam logic [6:0] WIN_LEN_RST  = WIN_HALF_RST ? 7'd0 :
                                         7'(7'd1 << (WIN_RST - 3'd1));
   localparam logic       USE_MOD_RST  = !MOD_CFG_RST[BYPASS_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [22:0] mod_cfg_q;   // Modulator configuration
   logic [23:0] lkd_ctl_q;   // Lock detector control
   logic [6:0]  vco_low_q;   // Low bits of last VCO indirect write
   logic [23:0] seed_q;      // Seed applied to modulator
   logic        seed_ld_q;   // Seed load pulse
   logic [16:0] tally_q;     // Consecutive in-window count
   logic        locked_q;    // Lock flag
   logic        cal_q;       // Calibration pulse
   logic [23:0] rd_q;        // Read data
   logic [2:0]  cmp_s_q;     // Comparison strobe sync and edge
   logic [1:0]  win_s_q;     // In-window sync
   logic        use_mod_q;   // Modulator output in use
   logic        win_half_q;  // Half-cycle window flag
   logic [6:0]  win_len_q;   // Window length in cycles

   ////////////////////////////////////////////////////////////////////////
   // Decode
   wire         wr_mod  = i_wr.wr && i_wr.addr == IDX_MOD_CFG;
   wire         wr_lkd  = i_wr.wr && i_wr.addr == IDX_LKD_CTL;
   wire         wr_vco  = i_wr.wr && i_wr.addr == IDX_VCO_SPI;
   wire         wr_int  = i_wr.wr && i_wr.addr == IDX_INT_DIV;
   wire         wr_fractional_divider = i_wr.wr && i_wr.addr == IDX_FRACTIONAL_DIVIDER_DIV;
   wire         core_on = mod_cfg_q[CORE_ON_BIT];
   wire         lkd_on  = lkd_ctl_q[LKD_ON_BIT];
   wire [1:0]   seed_sel = mod_cfg_q[SEED_LSB +: 2];
   wire [2:0]   lim_sel  = lkd_ctl_q[LIMIT_LSB +: 3];
   // Next register values, so decoded outputs move with the write
   wire [22:0]  mod_cfg_d = wr_mod ? (i_wr.data[22:0] & MOD_CFG_MASK)
                                   : mod_cfg_q;
   wire [23:0]  lkd_ctl_d = wr_lkd ? i_wr.data : lkd_ctl_q;
   wire [2:0]   win_sel  = lkd_ctl_d[WIN_LSB +: 3];
   // Window decode: code zero is the half-cycle window
   wire         win_half_d = win_sel == 3'd0;
   wire [6:0]   win_len_d  = win_half_d ? 7'd0 :
                             7'(7'd1 << (win_sel - 3'd1));
   wire         vco_armed = vco_low_q == '0;
   // Divider write picked by core enable
   wire         cal_trig = vco_armed &&
                           (core_on ? wr_fractional_divider : wr_int);
   wire         do_load  = i_freq_chg &&
                           mod_cfg_q[SEED_LD_BIT];
   // Comparison event and result
   wire         cmp_ev = cmp_s_q[1] && !cmp_s_q[2];
   wire         in_win = win_s_q[1];

   // Seed lookup
   logic [23:0] seed_val;
   always_comb
   begin
      unique case (seed_sel)
         2'd0: seed_val = SEED_ZERO;
         2'd1: seed_val = SEED_LSBV;
         2'd2: seed_val = SEED_A;
         2'd3: seed_val = SEED_B;
      endcase
   end

   // Lock count limit lookup
   logic [16:0] limit;
   always_comb
   begin
      unique case (lim_sel)
         3'd0: limit = LIM_0;
         3'd1: limit = LIM_1;
         3'd2: limit = LIM_2;
         3'd3: limit = LIM_3;
         3'd4: limit = LIM_4;
         3'd5: limit = LIM_5;
         3'd6: limit = LIM_6;
         3'd7: limit = LIM_7;
      endcase
   end

   // Read mux
   logic [23:0] rd_d;
   always_comb
   begin
      unique case (i_rd_addr)
         IDX_MOD_CFG: rd_d = {1'b0, mod_cfg_q};
         IDX_LKD_CTL: rd_d = lkd_ctl_q;
         default:     rd_d = '0;                // Unmapped reads zero
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cmp_s_q <= '0;
         win_s_q <= '0;
      end
      else if (i_ce)
      begin
         cmp_s_q <= {cmp_s_q[1:0], i_cmp};
         win_s_q <= {win_s_q[0], i_in_win};
      end
   end

   // Register writes
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         mod_cfg_q <= MOD_CFG_RST[22:0];
         lkd_ctl_q <= LKD_CTL_RST;
         vco_low_q <= '0;
      end
      else if (i_ce)
      begin
         if (wr_mod)
            mod_cfg_q <= i_wr.data[22:0] & MOD_CFG_MASK;
         if (wr_lkd)
            lkd_ctl_q <= i_wr.data;
         if (wr_vco)
            vco_low_q <= i_wr.data[6:0] & VCO_LOW_MASK;
      end
   end

   // Seed transfer on frequency change
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         seed_q    <= SEED_A;
         seed_ld_q <= 1'b0;
      end
      else if (i_ce)
      begin
         seed_ld_q <= do_load;
         if (do_load)
            seed_q <= seed_val;
      end
   end

   // Lock detector tally
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         tally_q  <= '0;
         locked_q <= 1'b0;
      end
      else if (i_ce)
      begin
         if (!lkd_on)
         begin
            tally_q  <= '0;
            locked_q <= 1'b0;
         end
         else if (cmp_ev && !in_win)
         begin
            tally_q  <= '0;
            locked_q <= 1'b0;
         end
         else if (cmp_ev)
         begin
            if (tally_q + 17'd1 >= limit)
               locked_q <= 1'b1;
            if (tally_q != LIM_7)
               tally_q <= tally_q + 17'd1;
         end
      end
   end

   // Decoded outputs, launched from flops in step with the register
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         use_mod_q  <= USE_MOD_RST;
         win_half_q <= WIN_HALF_RST;
         win_len_q  <= WIN_LEN_RST;
      end
      else if (i_ce)
      begin
         use_mod_q  <= !mod_cfg_d[BYPASS_BIT];
         win_half_q <= win_half_d;
         win_len_q  <= win_len_d;
      end
   end

   // Calibration pulse and read data
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cal_q <= 1'b0;
         rd_q  <= '0;
      end
      else if (i_ce)
      begin
         cal_q <= cal_trig;
         rd_q  <= rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign o_rd_data       = rd_q;
   assign o_mod.core_on   = mod_cfg_q[CORE_ON_BIT];
   assign o_mod.use_mod   = use_mod_q;
   assign o_mod.seed_load = seed_ld_q;
   assign o_mod.seed      = seed_q;
   assign o_win_half      = win_half_q;
   assign o_win_len       = win_len_q;
   assign o_cal_start     = cal_q;
   assign o_locked        = locked_q;
endmodule // fractional_divider_lock_cfg

// [tb/fractional_divider_lock_properties.sv]
// Checker: port-level properties of the modulator and lock block
`timescale 1ns/100ps
module fractional_divider_lock_properties
(
   input wire logic                   i_clk,       // Clock
   input wire logic                   i_arst_n,    // Reset, low
   input wire logic                   i_ce,        // Clock enable
   input wire fractional_divider_lock_pkg::reg_wr_t i_wr,        // Write
   input wire logic                   i_freq_chg,  // Frequency change
   input wire fractional_divider_lock_pkg::mod_ctl_t o_mod,      // Modulator control
   input wire logic [6:0]             o_win_len,   // Window cycles
   input wire logic                   o_win_half,  // Half window
   input wire logic                   o_cal_start  // Calibration pulse
);
   import fractional_divider_lock_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   wire wr_ok = i_wr.wr && i_ce;                    // Taken write
   wire cfg_wr = wr_ok && i_wr.addr == IDX_MOD_CFG; // Config write
   ////////////////////////////////////////////////////////////////////
   property p_ld; o_mod.seed_load |-> $past(i_freq_chg && i_ce); endproperty
   a_ld: assert property (p_ld) else $error("seed load no change");
   property p_sd; !o_mod.seed_load |-> $stable(o_mod.seed); endproperty
   a_sd: assert property (p_sd) else $error("seed moved");
   property p_c1; o_cal_start |=> !o_cal_start; endproperty
   a_c1: assert property (p_c1) else $error("cal pulse long");
   property p_c2; o_cal_start |-> $past(wr_ok) && $past(i_wr.addr) ==
      (o_mod.core_on ? IDX_FRACTIONAL_DIVIDER_DIV : IDX_INT_DIV); endproperty
   a_c2: assert property (p_c2) else $error("cal wrong cause");
   property p_use; cfg_wr |=>
      o_mod.use_mod == !$past(i_wr.data[BYPASS_BIT]); endproperty
   a_use: assert property (p_use) else $error("bypass wrong");
   property p_core; cfg_wr |=>
      o_mod.core_on == $past(i_wr.data[CORE_ON_BIT]); endproperty
   a_core: assert property (p_core) else $error("core on wrong");
   property p_half; o_win_half |-> o_win_len == 7'h00; endproperty
   a_half: assert property (p_half) else $error("half len");
   property p_pow; !o_win_half |-> $onehot(o_win_len); endproperty
   a_pow: assert property (p_pow) else $error("window len");
endmodule // fractional_divider_lock_properties
bind fractional_divider_lock_cfg fractional_divider_lock_properties chk_u (.i_clk(i_clk),
   .i_arst_n(i_arst_n), .i_ce(i_ce), .i_wr(i_wr), .i_freq_chg(i_freq_chg),
   .o_mod(o_mod), .o_win_len(o_win_len), .o_win_half(o_win_half),
   .o_cal_start(o_cal_start));

// [tb/tb_top.sv]
// Testbench: directed scenarios for the modulator and lock block
`timescale 1ns/100ps
module tb_top;
   import fractional_divider_lock_pkg::*;
   logic        i_clk = 1'b0;      // Clock
   logic        i_arst_n = 1'b0;   // Reset, low
   logic        i_ce = 1'b1;       // Clock enable
   reg_wr_t     i_wr = '0;         // Write strobe
   logic [4:0]  i_rd_addr = 5'h00; // Read index
   logic        i_freq_chg = 1'b0; // Frequency change
   logic        i_cmp = 1'b0;      // Comparison edge
   logic        i_in_win = 1'b0;   // In-window result
   logic [23:0] o_rd_data;         // Read data
   mod_ctl_t    o_mod;             // Modulator control
   logic [6:0]  o_win_len;         // Window cycles
   logic        o_win_half;        // Half window
   logic        o_cal_start;       // Calibration pulse
   logic        o_locked;          // Lock flag
   int          err_count = 0;     // Mismatches
   int          total_checks = 0;  // Comparisons
   logic [23:0] seeds [4] = '{SEED_ZERO, SEED_LSBV, SEED_A, SEED_B};
   fractional_divider_lock_cfg dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
      .i_wr(i_wr), .i_rd_addr(i_rd_addr), .i_freq_chg(i_freq_chg),
      .i_cmp(i_cmp), .i_in_win(i_in_win), .o_rd_data(o_rd_data),
      .o_mod(o_mod), .o_win_len(o_win_len), .o_win_half(o_win_half),
      .o_cal_start(o_cal_start), .o_locked(o_locked));
   ////////////////////////////////////////////////////////////////////
   // Clock, 10 ns period
   initial
   begin
      forever #5 i_clk = ~i_clk;
   end
   // Compare one value
   task automatic chk(input string nm, input logic [23:0] e, g);
      total_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Register write, taken at second edge
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      @(posedge i_clk);
      i_wr <= '{1'b1, a, d};
      @(posedge i_clk);
      i_wr.wr <= 1'b0;
      #1;
   endtask
   // Register read, data one cycle later
   task automatic rd(input logic [4:0] a, input logic [23:0] e);
      @(posedge i_clk);
      i_rd_addr <= a;
      @(posedge i_clk);
      #1;
      chk("rd_data", e, o_rd_data);
   endtask
   // Divider write, then calibration pulse
   task automatic wc(input logic [4:0] a, input logic e);
      wr(a, 24'h00_0019);
      chk("cal", 24'(e), 24'(o_cal_start));
   endtask
   // Frequency change pulse
   task automatic chg;
      @(posedge i_clk);
      i_freq_chg <= 1'b1;
      @(posedge i_clk);
      i_freq_chg <= 1'b0;
      #1;
   endtask
   // N comparisons with given result, then lock flag
   task automatic hits(input int n, input logic w, input logic e);
      repeat (n)
      begin
         @(posedge i_clk);
         i_in_win <= w;
         @(posedge i_clk);
         i_cmp <= 1'b1;
         repeat (3) @(posedge i_clk);
         i_cmp <= 1'b0;
         repeat (5) @(posedge i_clk);
      end
      #1;
      chk("locked", 24'(e), 24'(o_locked));
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(IDX_MOD_CFG, MOD_CFG_RST);
      rd(IDX_LKD_CTL, LKD_CTL_RST);
      rd(5'h1f, 24'h00_0000);
      chk("seed", SEED_A, o_mod.seed);
      $display("t_reset done");
   endtask
   // Write with clock enable low must leave the register untouched
   task automatic t_ce;
      @(posedge i_clk);
      i_ce <= 1'b0;
      wr(IDX_MOD_CFG, 24'h00_0000);
      i_ce <= 1'b1;
      rd(IDX_MOD_CFG, MOD_CFG_RST);
      chk("core_on", 24'h1, 24'(o_mod.core_on));
      $display("t_ce done");
   endtask
   task automatic t_seed;
      for (int c = 0; c < 4; c++)
      begin
         wr(IDX_MOD_CFG, 24'h00_0f00 | 24'(c));
         chg();
         chk("seed_load", 24'h1, 24'(o_mod.seed_load));
         chk("seed", seeds[c], o_mod.seed);
      end
      wr(IDX_MOD_CFG, 24'h00_0e01);
      rd(IDX_MOD_CFG, 24'h00_0e01);
      chg();
      chk("seed_load", 24'h0, 24'(o_mod.seed_load));
      chk("seed", SEED_B, o_mod.seed);
      $display("t_seed done");
   endtask
   task automatic t_cal;
      wr(IDX_VCO_SPI, 24'h00_0000);
      wr(IDX_MOD_CFG, 24'h00_0780);
      chk("use_mod", 24'h0, 24'(o_mod.use_mod));
      chk("core_on", 24'h0, 24'(o_mod.core_on));
      wc(IDX_FRACTIONAL_DIVIDER_DIV, 1'b0);
      wc(IDX_INT_DIV, 1'b1);
      wr(IDX_MOD_CFG, 24'h00_0f00);
      chk("core_on", 24'h1, 24'(o_mod.core_on));
      chk("use_mod", 24'h1, 24'(o_mod.use_mod));
      wc(IDX_INT_DIV, 1'b0);
      wc(IDX_FRACTIONAL_DIVIDER_DIV, 1'b1);
      wr(IDX_VCO_SPI, 24'h00_0001);
      wc(IDX_FRACTIONAL_DIVIDER_DIV, 1'b0);
      $display("t_cal done");
   endtask
   task automatic t_lock;
      wr(IDX_LKD_CTL, 24'h00_0148);
      hits(4, 1'b1, 1'b0);
      hits(1, 1'b1, 1'b1);
      hits(1, 1'b0, 1'b0);
      hits(4, 1'b1, 1'b0);
      hits(1, 1'b1, 1'b1);
      wr(IDX_LKD_CTL, 24'h00_0140);
      hits(1, 1'b1, 1'b0);
      wr(IDX_LKD_CTL, 24'h00_0149);
      hits(31, 1'b1, 1'b0);
      hits(1, 1'b1, 1'b1);
      hits(1, 1'b0, 1'b0);
      wr(IDX_LKD_CTL, 24'h00_014a);
      hits(95, 1'b1, 1'b0);
      hits(1, 1'b1, 1'b1);
      hits(1, 1'b0, 1'b0);
      wr(IDX_LKD_CTL, 24'h00_014b);
      hits(255, 1'b1, 1'b0);
      hits(1, 1'b1, 1'b1);
      $display("t_lock done");
   endtask
   task automatic t_win;
      for (int c = 0; c < 8; c++)
      begin
         logic [23:0] len_e;
         len_e = c == 0 ? 24'h0 : 24'h1 << (c - 1);
         wr(IDX_LKD_CTL, 24'h00_0048 | (24'(c) << WIN_LSB));
         chk("win_half", 24'(c == 0), 24'(o_win_half));
         chk("win_len", len_e, 24'(o_win_len));
      end
      $display("t_win done");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge i_clk);
      err_count++;
      print_verdict();
   end
   // Main sequence
   initial
   begin
      repeat (5) @(posedge i_clk);
      i_arst_n <= 1'b1;
      t_reset();
      t_ce();
      t_seed();
      t_cal();
      t_lock();
      t_win();
      print_verdict();
   end
endmodule // tb_top
